// ---- logic/led_cmd_consts.vh ----
// constants for the eight-channel led driver command front end
`ifndef LED_CMD_CONSTS_VH
`define LED_CMD_CONSTS_VH
`define DEV_ADDR        7'h1b
`define CTL_APPLY       3'h0
`define CTL_WRITE       3'h1
`define CTL_WRITE_APPLY 3'h2
`define CTL_ALL_LEVEL   3'h3
`define CTL_ALL_DUTY    3'h4
`define REG_LEVEL_BASE  5'h00
`define REG_CH8_LEVEL   5'h07
`define REG_DUTY_BASE   5'h08
`define REG_CH1_DUTY    5'h08
`define REG_ON_OFF      5'h10
`define REG_STATUS      5'h11
`define STATUS_LP_BIT   2
`define REG_RESET       8'h00
`define IDLE_TIME_US    5000
`define WAKE_TIME_US    1000
`define CLK_MHZ         100
`define IDLE_CYCLES     (`IDLE_TIME_US * `CLK_MHZ)
`define WAKE_CYCLES     (`WAKE_TIME_US * `CLK_MHZ / 2)
`endif

// ---- logic/led_cmd_ctrl.v ----
// i2c command interpreter, register file and low-power control
`timescale 1ns/100ps
`include "led_cmd_consts.vh"

// Functional notes
// R01: enter low power about 5 ms after all outputs off and bus idle.
// R02: in low power the serial port works and registers keep contents.
// R03: low_power_flag status bit reads one throughout low power.
// R04: bus transaction wakes device; flag clears once fully running.
// R05: wake-up to normal operation completes in under 1 ms.
// R06: master polls low_power_flag until zero after waking.
// R07: device answers only to 7-bit address 0011011.
// R08: write is address, command byte, data byte, each acknowledged.
// R09: code 011 writes data to all eight level registers.
// R10: code 100 writes data to all eight duty registers.
// R11: code 010 writes register and applies all pending settings.
// R12: code 001 writes register; outputs unchanged until 000 or 010.
// R13: code 000 has no data and applies pending settings.
// R14: read is 001 plus address, repeated start, address with read bit.
// R15: read returns value last written to addressed register.
// R16: address 00111 selects channel eight level register.
// R17: address 01000 selects channel one duty register.
// R18: address 10000 selects channel on/off register.
// R19: on/off bit n drives channel n+1, one means on.
// R20: every register clears to zero at reset.
// R21: idle timer restarts on own bus traffic or any channel on.
module led_cmd_ctrl
#(
  parameter IDLE_CYCLES = `IDLE_CYCLES,
  parameter WAKE_CYCLES = `WAKE_CYCLES
)
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // i2c pins, enables low while driving low
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n,
  // applied channel settings
  output reg  [63:0] level_out_q,
  output reg  [63:0] duty_out_q,
  output reg  [7:0]  chan_on_q,
  // power state
  output wire        low_power
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_CMD   = 3'd2;
  localparam ST_DATA  = 3'd3;
  localparam ST_READ  = 3'd4;
  localparam ST_SKIP  = 3'd5;

  localparam PM_RUN   = 2'd0;
  localparam PM_LOW   = 2'd1;
  localparam PM_WAKE  = 2'd2;

  // pin synchronisers
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg       scl_q;
  reg       sda_q;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev  = scl & scl_q & ~sda_q & sda;

  // register file: pending copies
  reg [7:0] level_q [0:7];
  reg [7:0] duty_q  [0:7];
  reg [7:0] on_off_q;

  reg [2:0] st_q;
  reg [7:0] shift_q;
  reg [3:0] bit_q;
  reg       ack_phase_q;
  reg       drive_low_q;
  reg [2:0] ctl_q;
  reg [4:0] ptr_q;
  reg       got_cmd_q;
  reg [1:0] pm_q;
  reg [31:0] idle_cnt_q;
  reg [31:0] wake_cnt_q;
  reg       bus_hit_q;

  function [7:0] reg_read;
    input [4:0] a;
    begin
      if (a < `REG_DUTY_BASE)
        reg_read = level_q[a[2:0]];
      else if (a < `REG_ON_OFF)
        reg_read = duty_q[a[2:0]];
      else if (a == `REG_ON_OFF)
        reg_read = on_off_q;
      else if (a == `REG_STATUS)
        reg_read = {5'h00, low_power, 2'b00}; // R03
      else
        reg_read = 8'h00;
    end
  endfunction

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low_q;
  assign low_power = (pm_q != PM_RUN); // R03 R04

  integer i;
  wire [7:0] byte_in = {shift_q[6:0], sda};

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        level_q[i] <= `REG_RESET; // R20
        duty_q[i]  <= `REG_RESET;
      end
      on_off_q    <= `REG_RESET;
      level_out_q <= 64'h0;
      duty_out_q  <= 64'h0;
      chan_on_q   <= 8'h00;
      st_q        <= ST_IDLE;
      shift_q     <= 8'h00;
      bit_q       <= 4'h0;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
      ctl_q       <= 3'h0;
      ptr_q       <= 5'h00;
      got_cmd_q   <= 1'b0;
      bus_hit_q   <= 1'b0;
    end
    else
    begin
      bus_hit_q <= 1'b0;
      if (start_ev)
      begin
        // repeated start keeps the pointer for read-back
        st_q        <= ST_ADDR; // R14
        bit_q       <= 4'h0;
        ack_phase_q <= 1'b0;
        drive_low_q <= 1'b0;
        got_cmd_q   <= 1'b0;
      end
      else if (stop_ev)
      begin
        // apply-only command has no data byte, act on stop
        if (got_cmd_q && ctl_q == `CTL_APPLY)
        begin
          for (i = 0; i < 8; i = i + 1)
          begin
            level_out_q[i*8 +: 8] <= level_q[i]; // R13
            duty_out_q[i*8 +: 8]  <= duty_q[i];
          end
          chan_on_q <= on_off_q;
        end
        st_q        <= ST_IDLE;
        drive_low_q <= 1'b0;
        got_cmd_q   <= 1'b0;
      end
      else if (st_q == ST_SKIP)
      begin
        // let go of the ack at the next scl fall, or stop is never seen
        if (scl_fall && ack_phase_q)
        begin
          ack_phase_q <= 1'b0;
          drive_low_q <= 1'b0;
        end
      end
      else if (st_q != ST_IDLE && st_q != ST_SKIP)
      begin
        if (scl_rise && !ack_phase_q)
        begin
          shift_q <= byte_in;
          bit_q   <= bit_q + 4'h1;
        end
        else if (scl_rise && ack_phase_q && st_q == ST_READ)
        begin
          if (sda)
            st_q <= ST_SKIP; // master nack ends the read
        end
        else if (scl_fall)
        begin
          if (ack_phase_q)
          begin
            ack_phase_q <= 1'b0;
            drive_low_q <= 1'b0;
            bit_q       <= 4'h0;
            if (st_q == ST_READ)
              drive_low_q <= ~shift_q[7];
          end
          else if (st_q == ST_READ && bit_q != 4'h8)
          begin
            drive_low_q <= ~shift_q[7];
          end
          else if (bit_q == 4'h8)
          begin
            ack_phase_q <= 1'b1;
            drive_low_q <= 1'b0;
            case (st_q)
              ST_ADDR:
              begin
                if (shift_q[7:1] == `DEV_ADDR) // R07
                begin
                  drive_low_q <= 1'b1;
                  bus_hit_q   <= 1'b1; // R21
                  if (shift_q[0])
                  begin
                    st_q    <= ST_READ;
                    shift_q <= reg_read(ptr_q); // R15
                  end
                  else
                    st_q <= ST_CMD;
                end
                else
                  st_q <= ST_SKIP;
              end
              ST_CMD:
              begin
                drive_low_q <= 1'b1; // R08
                ctl_q       <= shift_q[7:5];
                ptr_q       <= shift_q[4:0];
                got_cmd_q   <= 1'b1;
                st_q        <= ST_DATA;
              end
              ST_DATA:
              begin
                drive_low_q <= 1'b1;
                got_cmd_q   <= 1'b0;
                st_q        <= ST_SKIP;
                case (ctl_q)
                  `CTL_ALL_LEVEL:
                    for (i = 0; i < 8; i = i + 1)
                      level_q[i] <= shift_q; // R09
                  `CTL_ALL_DUTY:
                    for (i = 0; i < 8; i = i + 1)
                      duty_q[i] <= shift_q; // R10
                  `CTL_WRITE, `CTL_WRITE_APPLY:
                  begin
                    if (ptr_q < `REG_DUTY_BASE)
                      level_q[ptr_q[2:0]] <= shift_q; // R16
                    else if (ptr_q < `REG_ON_OFF)
                      duty_q[ptr_q[2:0]] <= shift_q; // R17
                    else if (ptr_q == `REG_ON_OFF)
                      on_off_q <= shift_q; // R18 R12
                  end
                  default:
                    drive_low_q <= 1'b1;
                endcase
              end
              ST_READ:
                drive_low_q <= 1'b0;
              default:
                st_q <= ST_SKIP;
            endcase
          end
        end
      end
      // apply at the scl rise of the data ack slot, after the data byte lands, so new data is seen
      if (ack_phase_q && scl_rise && st_q == ST_SKIP &&
          ctl_q == `CTL_WRITE_APPLY && !got_cmd_q && drive_low_q)
      begin
        for (i = 0; i < 8; i = i + 1)
        begin
          level_out_q[i*8 +: 8] <= level_q[i]; // R11
          duty_out_q[i*8 +: 8]  <= duty_q[i];
        end
        chan_on_q <= on_off_q; // R19
      end
    end
  end

  // low-power manager; registers are untouched by it
  wire any_on = |chan_on_q;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pm_q       <= PM_RUN;
      idle_cnt_q <= 32'h0;
      wake_cnt_q <= 32'h0;
    end
    else
    begin
      case (pm_q)
        PM_RUN:
        begin
          if (any_on || bus_hit_q)
            idle_cnt_q <= 32'h0; // R21
          else if (idle_cnt_q == IDLE_CYCLES - 1)
          begin
            pm_q       <= PM_LOW; // R01
            idle_cnt_q <= 32'h0;
          end
          else
            idle_cnt_q <= idle_cnt_q + 32'h1;
        end
        PM_LOW:
        begin
          // serial logic keeps running here so the wake can be seen
          if (start_ev) // R02 R04
          begin
            pm_q       <= PM_WAKE;
            wake_cnt_q <= 32'h0;
          end
        end
        PM_WAKE:
        begin
          if (wake_cnt_q == WAKE_CYCLES - 1)
            pm_q <= PM_RUN; // R05
          else
            wake_cnt_q <= wake_cnt_q + 32'h1;
        end
        default:
          pm_q <= PM_RUN;
      endcase
    end
  end

endmodule

// ---- test/led_cmd_ctrl_monitor.sv ----
// port checks for the led command front end
`timescale 1ns/100ps
module led_cmd_ctrl_monitor
#(
  parameter IDLE_CYCLES = 500000,
  parameter WAKE_CYCLES = 50000
)
(
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // bus pins
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_oe_n,
  // outputs
  input wire [63:0] level_out_q,
  input wire [63:0] duty_out_q,
  input wire [7:0]  chan_on_q,
  input wire        low_power
);
  reg [31:0] dark_q;
  reg [31:0] quiet_q;
  reg [31:0] wake_q;
  reg        woke_q;
  reg        scl_q;
  reg        sda_q;
  wire       lit = |chan_on_q;
  wire       strt = scl_q & sda_q & scl_in & ~sda_in;
  // any pin low counts as traffic, so quiet_q never runs ahead of the dut before a wake, and after one leads it by up to WAKE_CYCLES
  wire       busy = rst | lit | ~scl_in | ~sda_in | ~scl_q | ~sda_q;
  always @(posedge clk_sys)
  begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    dark_q <= (rst | lit) ? 32'h0 : dark_q + 32'h1;
    quiet_q <= busy ? 32'h0 : quiet_q + 32'h1;
    woke_q <= ~rst & low_power & (woke_q | strt);
    wake_q <= (woke_q & low_power) ? wake_q + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (
    $fell(rst) |-> sda_oe_n && !low_power && !lit &&
    level_out_q == 64'h0 && duty_out_q == 64'h0)
    else $error("outputs not clear after reset");
  a_ack_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_lp_dark: assert property (
    $rose(low_power) |-> dark_q >= IDLE_CYCLES - 2)
    else $error("low power entered too early");
  a_lp_enter: assert property (
    quiet_q == IDLE_CYCLES + 8 |-> low_power)
    else $error("low power not entered");
  a_lp_stays: assert property (
    low_power && !woke_q |=> low_power)
    else $error("low power flag dropped without start");
  a_wake_cause: assert property (
    $fell(low_power) |-> woke_q)
    else $error("wake without bus start");
  a_wake_bound: assert property (
    wake_q <= WAKE_CYCLES + 8)
    else $error("wake took too long");
  a_lp_hold: assert property (
    low_power && !woke_q |=> $stable(chan_on_q) &&
    $stable(level_out_q) && $stable(duty_out_q))
    else $error("outputs moved in low power");
  c_lp_in: cover property ($rose(low_power));
  c_lp_out: cover property ($fell(low_power));
  c_apply: cover property ($changed(chan_on_q));
endmodule

// ---- test/i2c_host_model.sv ----
// open-drain i2c bus master for the led command front end
`timescale 1ns/100ps
module i2c_host_model
(
  // clock
  input  wire clk_sys,
  // bus lines, pulled up when released
  output wire scl_in,
  output wire sda_in,
  input  wire sda_out,
  input  wire sda_oe_n
);
  reg scl_q = 1'b1;
  reg sda_q = 1'b1;
  assign scl_in = scl_q;
  assign sda_in = sda_q & (sda_oe_n | sda_out);
  // 10 clocks a step keeps well above the 3 the synchroniser needs
  task tick;
  begin
    repeat (10) @(posedge clk_sys);
    #1;
  end
  endtask
  task start;
  begin
    sda_q = 1'b1;
    tick;
    scl_q = 1'b1;
    tick;
    sda_q = 1'b0;
    tick;
    scl_q = 1'b0;
    tick;
  end
  endtask
  task stop;
  begin
    sda_q = 1'b0;
    tick;
    scl_q = 1'b1;
    tick;
    sda_q = 1'b1;
    tick;
  end
  endtask
  // eight bits then the ack slot; sda moves only while scl is low
  task xfer;
    input  [8:0] d;
    output [8:0] r;
    integer      i;
  begin
    for (i = 8; i >= 0; i = i - 1)
    begin
      sda_q = d[i];
      tick;
      scl_q = 1'b1;
      tick;
      r[i] = sda_in;
      scl_q = 1'b0;
      tick;
    end
  end
  endtask
endmodule

// ---- test/led_driver_i2c_command_lowpower_bench.sv ----
// self-checking bench for the led command front end
`timescale 1ns/100ps
`include "led_cmd_consts.vh"
module led_driver_i2c_command_lowpower_bench;
  localparam IDLE = 3000;
  localparam WAKE = 2000;
  reg         clk_sys;
  reg         rst = 1'b1;
  wire        scl_in;
  wire        sda_in;
  wire        sda_out;
  wire        sda_oe_n;
  wire [63:0] level_out_q;
  wire [63:0] duty_out_q;
  wire [7:0]  chan_on_q;
  wire        low_power;
  integer     err_count = 0;
  integer     compares = 0;
  reg  [8:0]  rx;
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  led_cmd_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .level_out_q(level_out_q),
    .duty_out_q(duty_out_q), .chan_on_q(chan_on_q),
    .low_power(low_power));
  i2c_host_model u_host (.clk_sys(clk_sys), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  task check(input [63:0] seen, input [63:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task wr(input [2:0] c, input [4:0] a, input [7:0] d, input dat);
  begin
    u_host.start;
    u_host.xfer({`DEV_ADDR, 2'b01}, rx);
    check(64'(rx[0]), 64'h0);
    u_host.xfer({c, a, 1'b1}, rx);
    check(64'(rx[0]), 64'h0);
    if (dat)
    begin
      u_host.xfer({d, 1'b1}, rx);
      check(64'(rx[0]), 64'h0);
    end
    u_host.stop;
  end
  endtask
  task rd(input [4:0] a, input [7:0] exp);
  begin
    u_host.start;
    u_host.xfer({`DEV_ADDR, 2'b01}, rx);
    u_host.xfer({`CTL_WRITE, a, 1'b1}, rx);
    u_host.start;
    u_host.xfer({`DEV_ADDR, 2'b11}, rx);
    u_host.xfer(9'h1ff, rx);
    check(64'(rx[8:1]), 64'(exp));
    u_host.stop;
  end
  endtask
  task wait_lp(input lvl, input integer n);
    integer i;
  begin
    for (i = 0; low_power !== lvl && i < n; i = i + 1)
    begin
      @(posedge clk_sys);
      #1;
    end
    check(64'(low_power), 64'(lvl));
    if (i >= n)
      report_and_stop;
  end
  endtask
  task t_pending;
  begin
    rd(`REG_ON_OFF, 8'h00);
    wr(`CTL_WRITE, `REG_CH8_LEVEL, 8'h0b, 1'b1);
    wr(`CTL_WRITE, `REG_ON_OFF, 8'h8f, 1'b1);
    check(64'(chan_on_q) | level_out_q, 64'h0);
    rd(`REG_CH8_LEVEL, 8'h0b);
    wr(`CTL_APPLY, 5'h1f, 8'h00, 1'b0);
    check(64'(chan_on_q), 64'h8f);
    check(level_out_q, 64'h0b00_0000_0000_0000);
  end
  endtask
  task t_broadcast;
  begin
    wr(`CTL_ALL_LEVEL, 5'h10, 8'h05, 1'b1);
    wr(`CTL_ALL_DUTY, 5'h10, 8'h20, 1'b1);
    rd(`REG_ON_OFF, 8'h8f);
    rd(`REG_CH1_DUTY, 8'h20);
    check(duty_out_q, 64'h0);
    wr(`CTL_WRITE_APPLY, `REG_ON_OFF, 8'h0f, 1'b1);
    check(level_out_q, {8{8'h05}});
    check(duty_out_q, {8{8'h20}});
    check(64'(chan_on_q), 64'h0f);
  end
  endtask
  task t_foreign;
  begin
    u_host.start;
    u_host.xfer({7'h1c, 2'b01}, rx);
    check(64'(rx[0]), 64'h1);
    u_host.stop;
  end
  endtask
  task t_low_power;
  begin
    wr(`CTL_WRITE_APPLY, `REG_ON_OFF, 8'h00, 1'b1);
    repeat (IDLE / 2) @(posedge clk_sys);
    #1;
    check(64'(low_power), 64'h0);
    wait_lp(1'b1, IDLE);
    repeat (100) @(posedge clk_sys);
    #1;
    check(64'(low_power), 64'h1);
    rd(`REG_STATUS, 8'h04);
    wait_lp(1'b0, WAKE);
    rd(`REG_CH1_DUTY, 8'h20);
    rd(`REG_STATUS, 8'h00);
    check(level_out_q, {8{8'h05}});
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    t_pending;
    t_broadcast;
    t_foreign;
    t_low_power;
    report_and_stop;
  end
endmodule
bind led_cmd_ctrl led_cmd_ctrl_monitor #(.IDLE_CYCLES(IDLE_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)) u_mon (.clk_sys(clk_sys), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .level_out_q(level_out_q), .duty_out_q(duty_out_q),
  .chan_on_q(chan_on_q), .low_power(low_power));
